// ---- logic/nsi_pkg.sv ----
package nsi_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_KHZ     = 25000;
  localparam int unsigned STRETCH_MS  = 50;
  // Product stays far below two to the thirty-first
  localparam int unsigned STRETCH_CYC = STRETCH_MS * CLK_KHZ;
  localparam int          CNT_W       = 21;

  // ==========================================================
  // Reversed-polarity thresholds
  // ==========================================================
  localparam logic [2:0] LINK_REV_LIMIT = 3'h7;
  localparam logic [1:0] PKT_REV_LIMIT  = 2'h3;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  // Control fields
  localparam int CTRL_POL_CLR   = 0;
  localparam int CTRL_LAMP_TEST = 1;
  localparam logic CTRL_LAMP_RST = 1'h0;

  // Status fields
  localparam int ST_EXT_CODEC  = 0;
  localparam int ST_MEDIA      = 1;
  localparam int ST_LINK_TEST  = 2;
  localparam int ST_LOW_SQL    = 3;
  localparam int ST_LINK_GOOD  = 4;
  localparam int ST_POLARITY   = 5;
  localparam int ST_TX_IND     = 6;
  localparam int ST_RX_IND     = 7;
  localparam int ST_COLL_IND   = 8;
  localparam int ST_LOCKED     = 9;

  // ==========================================================
  // Dual-function pin slots
  // ==========================================================
  localparam int DUAL_CRS = 0;
  localparam int DUAL_COL = 1;
  localparam int DUAL_RXD = 2;
  localparam int DUAL_RXC = 3;
  localparam int DUAL_TXC = 4;
  localparam int DUAL_N   = 5;

  // Indicator slots
  localparam int IND_TX   = 0;
  localparam int IND_RX   = 1;
  localparam int IND_COLL = 2;
  localparam int IND_N    = 3;

  // Strap capture sequence after reset release
  typedef enum logic [1:0] {
    NSI_STRAP_WAIT0   = 2'b00,
    NSI_STRAP_WAIT1   = 2'b01,
    NSI_STRAP_CAPTURE = 2'b10,
    NSI_STRAP_LOCKED  = 2'b11
  } nsi_strap_t;

endpackage

// ---- logic/nsi_top.sv ----
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
module nsi_top #(
  parameter int unsigned P_STRETCH_CYC = nsi_pkg::STRETCH_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  // Strap pins
  input  wire logic        i_ext_codec_sel,
  input  wire logic        i_media_sel,
  input  wire logic        i_link_test_dis_n,
  input  wire logic        i_low_squelch_sel,
  // Activity from MAC and twisted pair module (same clock)
  input  wire logic        i_tx_active,
  input  wire logic        i_rx_detect,
  input  wire logic        i_coll_detect,
  input  wire logic        i_link_pulse,
  input  wire logic        i_link_pulse_rev,
  input  wire logic        i_rx_pkt_end,
  input  wire logic        i_rx_pkt_rev,
  input  wire logic        i_link_good,
  // Dual-function pins and their internal ends
  input  wire logic [4:0]  i_dual_pin,
  output logic      [4:0]  o_dual_pin,
  output logic      [4:0]  o_dual_oe_n,
  input  wire logic [4:0]  i_dual_int,
  output logic      [4:0]  o_dual_mac,
  // Mode selections
  output logic             o_int_codec_en,
  output logic             o_aui_en,
  output logic             o_tp_module_en,
  output logic             o_link_pulse_gen_en,
  output logic             o_link_check_en,
  output logic             o_low_squelch_en,
  // Indicators, active low
  output logic             o_tx_ind_n,
  output logic             o_rx_ind_n,
  output logic             o_coll_ind_n,
  output logic             o_polarity_ind_n,
  output logic             o_link_ind_n,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp
);

  localparam int CW = nsi_pkg::CNT_W;
  localparam logic [CW-1:0] STRETCH_LOAD = CW'(P_STRETCH_CYC - 1);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [3:0] strap_s1_q;
  logic [3:0] strap_s2_q;
  logic [4:0] dual_s1_q;
  logic [4:0] dual_s2_q;

  // Two stages; only the second stage is read downstream
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      strap_s1_q <= 4'h0;
      strap_s2_q <= 4'h0;
      dual_s1_q  <= 5'h00;
      dual_s2_q  <= 5'h00;
    end
    else
    begin
      strap_s1_q <= {i_low_squelch_sel, i_link_test_dis_n,
                     i_media_sel, i_ext_codec_sel};
      strap_s2_q <= strap_s1_q;
      dual_s1_q  <= i_dual_pin;
      dual_s2_q  <= dual_s1_q;
    end
  end

  // ==========================================================
  // Strap capture
  // ==========================================================
  nsi_pkg::nsi_strap_t strap_st_q;
  nsi_pkg::nsi_strap_t strap_st_d;
  logic                ext_q;
  logic                media_q;
  logic                link_test_q;
  logic                low_sql_q;
  logic                locked;

  // Straps are static, so they are caught once the synchroniser is full
  always_comb
  begin
    strap_st_d = strap_st_q;
    unique case (strap_st_q)
      nsi_pkg::NSI_STRAP_WAIT0:   strap_st_d = nsi_pkg::NSI_STRAP_WAIT1;
      nsi_pkg::NSI_STRAP_WAIT1:   strap_st_d = nsi_pkg::NSI_STRAP_CAPTURE;
      nsi_pkg::NSI_STRAP_CAPTURE: strap_st_d = nsi_pkg::NSI_STRAP_LOCKED;
      nsi_pkg::NSI_STRAP_LOCKED:  strap_st_d = nsi_pkg::NSI_STRAP_LOCKED;
    endcase
  end

  assign locked = (strap_st_q == nsi_pkg::NSI_STRAP_LOCKED);

  // Latched once: a strap moving later is a board fault and is ignored
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      strap_st_q  <= nsi_pkg::NSI_STRAP_WAIT0;
      ext_q       <= 1'b0;
      media_q     <= 1'b0;
      link_test_q <= 1'b0;
      low_sql_q   <= 1'b0;
    end
    else
    begin
      strap_st_q <= strap_st_d;
      if (strap_st_q == nsi_pkg::NSI_STRAP_CAPTURE)
      begin
        ext_q       <= strap_s2_q[0];
        media_q     <= strap_s2_q[1];
        link_test_q <= strap_s2_q[2];
        low_sql_q   <= strap_s2_q[3];
      end
    end
  end

  // ==========================================================
  // Mode outputs
  // ==========================================================
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_int_codec_en      <= 1'b0;
      o_aui_en            <= 1'b0;
      o_tp_module_en      <= 1'b0;
      o_link_pulse_gen_en <= 1'b0;
      o_link_check_en     <= 1'b0;
      o_low_squelch_en    <= 1'b0;
    end
    else
    begin
      o_int_codec_en      <= locked & ~ext_q;
      o_aui_en            <= locked & media_q;
      o_tp_module_en      <= locked & ~media_q;
      o_link_pulse_gen_en <= locked & link_test_q;
      o_link_check_en     <= locked & link_test_q;
      o_low_squelch_en    <= locked & low_sql_q;
    end
  end

  // ==========================================================
  // Dual-function pin routing
  // ==========================================================
  genvar gd;
  generate
    for (gd = 0; gd < nsi_pkg::DUAL_N; gd++)
    begin : g_dual
      // Internal codec drives the pin; external codec feeds the MAC
      always_ff @(posedge i_ref_clk or negedge i_nrst)
      begin
        if (!i_nrst)
        begin
          o_dual_pin[gd]  <= 1'b0;
          o_dual_oe_n[gd] <= 1'b1;
          o_dual_mac[gd]  <= 1'b0;
        end
        else
        begin
          o_dual_pin[gd]  <= ~ext_q & i_dual_int[gd];
          o_dual_oe_n[gd] <= ~locked | ext_q;
          o_dual_mac[gd]  <= ext_q ? dual_s2_q[gd]
                                   : i_dual_int[gd];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Register bus
  // ==========================================================
  logic        acc_ok;
  logic        wr_pend_q;
  logic [31:0] wr_addr_q;
  logic        lamp_q;
  logic        pol_clr;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic        pol_q;

  // Word-aligned exact match; anything else is unmapped
  function automatic logic reg_hit(input logic [31:0] a,
                                   input logic [31:0] off);
    reg_hit = (a == off);
  endfunction

  assign acc_ok  = i_hsel & i_hready & (i_htrans == nsi_pkg::HTRANS_NONSEQ);
  assign pol_clr = wr_pend_q & reg_hit(wr_addr_q, nsi_pkg::ADDR_CTRL)
                 & i_hwdata[nsi_pkg::CTRL_POL_CLR];

  // Status shows strap values and live indicator state
  assign status_word = {22'h00_0000, locked, ~o_coll_ind_n, ~o_rx_ind_n,
                        ~o_tx_ind_n, pol_q, i_link_good, low_sql_q,
                        link_test_q, media_q, ext_q};
  assign rd_word = reg_hit(i_haddr, nsi_pkg::ADDR_STATUS) ? status_word :
                   reg_hit(i_haddr, nsi_pkg::ADDR_CTRL)
                     ? {30'h0, lamp_q, 1'b0} : 32'h0000_0000;

  // Zero wait states; read data is prepared during the address phase
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 32'h0000_0000;
      lamp_q      <= nsi_pkg::CTRL_LAMP_RST;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
    else
    begin
      wr_pend_q <= acc_ok & i_hwrite;
      if (acc_ok)
        wr_addr_q <= i_haddr;
      if (acc_ok & ~i_hwrite)
        o_hrdata <= rd_word;
      if (wr_pend_q & reg_hit(wr_addr_q, nsi_pkg::ADDR_CTRL))
        lamp_q <= i_hwdata[nsi_pkg::CTRL_LAMP_TEST];
    end
  end

  // ==========================================================
  // Stretched activity indicators
  // ==========================================================
  logic [2:0]    evt;
  logic [2:0]    ind_n_q;
  logic [CW-1:0] cnt_q [nsi_pkg::IND_N];

  assign evt[nsi_pkg::IND_TX]   = i_tx_active;
  assign evt[nsi_pkg::IND_RX]   = i_rx_detect;
  assign evt[nsi_pkg::IND_COLL] = i_coll_detect;

  genvar gi;
  generate
    for (gi = 0; gi < nsi_pkg::IND_N; gi++)
    begin : g_ind
      // Reload on every event so long activity keeps the lamp lit
      always_ff @(posedge i_ref_clk or negedge i_nrst)
      begin
        if (!i_nrst)
        begin
          cnt_q[gi]   <= '0;
          ind_n_q[gi] <= 1'b1;
        end
        else if (evt[gi])
        begin
          cnt_q[gi]   <= STRETCH_LOAD;
          ind_n_q[gi] <= 1'b0;
        end
        else if (cnt_q[gi] != '0)
        begin
          cnt_q[gi]   <= cnt_q[gi] - 1'b1;
          ind_n_q[gi] <= 1'b0;
        end
        else
          ind_n_q[gi] <= 1'b1;
      end
    end
  endgenerate

  // ==========================================================
  // Polarity detection
  // ==========================================================
  logic [2:0] link_rev_q;
  logic [1:0] pkt_rev_q;
  logic       tp_live;
  logic       pulse_rev;
  logic       pkt_rev;
  logic       pol_set;

  assign tp_live   = locked & ~media_q;
  assign pulse_rev = tp_live & i_link_pulse & i_link_pulse_rev;
  assign pkt_rev   = tp_live & i_rx_pkt_end & i_rx_pkt_rev;
  // At or past the limit, so a run that saturated can set again after clear
  assign pol_set   = (pulse_rev &
                      (link_rev_q >= nsi_pkg::LINK_REV_LIMIT - 3'h1))
                   | (pkt_rev &
                      (pkt_rev_q >= nsi_pkg::PKT_REV_LIMIT - 2'h1));

  // Any correctly polarised pulse or packet breaks its run
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      link_rev_q <= 3'h0;
      pkt_rev_q  <= 2'h0;
      pol_q      <= 1'b0;
    end
    else
    begin
      if (tp_live & i_link_pulse)
        link_rev_q <= ~i_link_pulse_rev ? 3'h0 :
                      (link_rev_q == nsi_pkg::LINK_REV_LIMIT) ? link_rev_q :
                      link_rev_q + 3'h1;
      if (tp_live & i_rx_pkt_end)
        pkt_rev_q <= ~i_rx_pkt_rev ? 2'h0 :
                     (pkt_rev_q == nsi_pkg::PKT_REV_LIMIT) ? pkt_rev_q :
                     pkt_rev_q + 2'h1;
      // Set wins over a clear in the same cycle
      if (pol_set)
        pol_q <= 1'b1;
      else if (pol_clr | (tp_live & i_rx_pkt_end & ~i_rx_pkt_rev))
        pol_q <= 1'b0;
    end
  end

  // ==========================================================
  // Indicator outputs
  // ==========================================================
  logic link_on;

  // Attachment mode forces the lamp off even with testing disabled
  assign link_on = locked & ~media_q
                 & (~link_test_q | i_link_good);

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_tx_ind_n       <= 1'b1;
      o_rx_ind_n       <= 1'b1;
      o_coll_ind_n     <= 1'b1;
      o_polarity_ind_n <= 1'b1;
      o_link_ind_n     <= 1'b1;
    end
    else
    begin
      o_tx_ind_n       <= ind_n_q[nsi_pkg::IND_TX] & ~lamp_q;
      o_rx_ind_n       <= ind_n_q[nsi_pkg::IND_RX] & ~lamp_q;
      o_coll_ind_n     <= ind_n_q[nsi_pkg::IND_COLL] & ~lamp_q;
      o_polarity_ind_n <= ~pol_q & ~lamp_q;
      o_link_ind_n     <= ~(link_on | lamp_q);
    end
  end

endmodule

// ---- sim/nsi_checker.sv ----
`timescale 1ns/1ns
// ==========================================================
// Port checks of the lamp and strap logic
// ==========================================================
module nsi_checker #(
  parameter int unsigned P_STRETCH_CYC = 8
) (
  input wire logic       i_ref_clk,
  input wire logic       i_nrst,
  input wire logic       i_tx_active,
  input wire logic       i_rx_detect,
  input wire logic       i_coll_detect,
  input wire logic       i_link_pulse,
  input wire logic       i_link_pulse_rev,
  input wire logic       i_link_good,
  input wire logic [4:0] o_dual_oe_n,
  input wire logic       o_int_codec_en,
  input wire logic       o_aui_en,
  input wire logic       o_tp_module_en,
  input wire logic       o_link_check_en,
  input wire logic       o_tx_ind_n,
  input wire logic       o_rx_ind_n,
  input wire logic       o_coll_ind_n,
  input wire logic       o_polarity_ind_n,
  input wire logic       o_link_ind_n
);
  logic [31:0] gap_q;
  logic [2:0]  rev_q;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // Saturating counters, so a long idle never wraps round
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      gap_q <= 32'hFFFF_FFFF;
      rev_q <= 3'h0;
    end
    else
    begin
      if (i_tx_active)
        gap_q <= 32'h1;
      else if (gap_q != 32'hFFFF_FFFF)
        gap_q <= gap_q + 32'h1;
      if (i_link_pulse && o_tp_module_en)
        rev_q <= !i_link_pulse_rev ? 3'h0 : (rev_q == 3'h7) ? 3'h7
                 : rev_q + 3'h1;
    end
  end
  property p_tx_on; i_tx_active |-> ##2 !o_tx_ind_n; endproperty
  a_tx_on: assert property (p_tx_on)
    else $error("tx lamp not lit");
  property p_rx_on; $rose(i_rx_detect) |=> ##1 !o_rx_ind_n; endproperty
  a_rx_on: assert property (p_rx_on)
    else $error("rx lamp not lit");
  property p_coll_on; i_coll_detect ##1 1'b1 |=> !o_coll_ind_n; endproperty
  a_coll_on: assert property (p_coll_on)
    else $error("collision lamp not lit");
  property p_tx_hold;
    (gap_q >= 32'h2 && gap_q <= P_STRETCH_CYC + 1) |-> !o_tx_ind_n;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx lamp dropped early");
  property p_aui_dark; o_aui_en |=> o_link_ind_n; endproperty
  a_aui_dark: assert property (p_aui_dark)
    else $error("link lamp lit in attachment mode");
  property p_dis_lit;
    (o_tp_module_en && !o_link_check_en) |=> !o_link_ind_n;
  endproperty
  a_dis_lit: assert property (p_dis_lit)
    else $error("link lamp dark with testing off");
  property p_good_lit;
    (o_tp_module_en && o_link_check_en && i_link_good) |=> !o_link_ind_n;
  endproperty
  a_good_lit: assert property (p_good_lit)
    else $error("link lamp dark on good link");
  property p_pins_driven; o_int_codec_en |=> o_dual_oe_n == 5'h00; endproperty
  a_pins_driven: assert property (p_pins_driven)
    else $error("dual pins not driven");
  property p_pol_set;
    (i_link_pulse && i_link_pulse_rev && o_tp_module_en && rev_q == 3'h6)
      |-> ##2 !o_polarity_ind_n;
  endproperty
  a_pol_set: assert property (p_pol_set)
    else $error("polarity lamp not lit");
endmodule
bind nsi_top nsi_checker #(.P_STRETCH_CYC(P_STRETCH_CYC)) u_chk (
  .i_ref_clk, .i_nrst, .i_tx_active, .i_rx_detect, .i_coll_detect,
  .i_link_pulse, .i_link_pulse_rev, .i_link_good, .o_dual_oe_n,
  .o_int_codec_en, .o_aui_en, .o_tp_module_en, .o_link_check_en,
  .o_tx_ind_n, .o_rx_ind_n, .o_coll_ind_n, .o_polarity_ind_n,
  .o_link_ind_n
);

// ---- sim/nsi_far_end.sv ----
`timescale 1ns/1ns
// ==========================================================
// External codec on the dual-function pins
// ==========================================================
module nsi_far_end (
  input  wire logic       i_ref_clk,
  input  wire logic [4:0] i_oe_n,
  input  wire logic [4:0] i_dev_pin,
  input  wire logic [4:0] i_tx_word,
  output logic      [4:0] o_pin
);
  logic [4:0] drv_q;
  // Codec drives only lines the device has let go
  assign o_pin = (i_oe_n & drv_q) | (~i_oe_n & i_dev_pin);
  // One cycle of codec latency, so the sync path sees a real delay
  always_ff @(posedge i_ref_clk)
    drv_q <= i_tx_word;
endmodule

// ---- sim/nsi_top_test.sv ----
`timescale 1ns/1ns
module nsi_top_test;
  localparam int unsigned P = 8; // Short hold keeps the run brief
  logic i_ref_clk = 1'b0, i_nrst = 1'b0, i_ext_codec_sel = 1'b0;
  logic i_media_sel = 1'b0, i_link_test_dis_n = 1'b1;
  logic i_low_squelch_sel = 1'b0, i_tx_active = 1'b0, i_rx_detect = 1'b0;
  logic i_coll_detect = 1'b0, i_link_pulse = 1'b0, i_link_good = 1'b0;
  logic i_link_pulse_rev = 1'b0, i_rx_pkt_end = 1'b0, i_rx_pkt_rev = 1'b0;
  logic [4:0] i_dual_pin, o_dual_pin, o_dual_oe_n, o_dual_mac;
  logic [4:0] i_dual_int = 5'h00, ext_word = 5'h00;
  logic o_int_codec_en, o_aui_en, o_tp_module_en, o_link_pulse_gen_en;
  logic o_link_check_en, o_low_squelch_en, o_tx_ind_n, o_rx_ind_n;
  logic o_coll_ind_n, o_polarity_ind_n, o_link_ind_n, o_hreadyout, o_hresp;
  logic i_hsel = 1'b0, i_hwrite = 1'b0, i_hready;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, rd_data;
  logic [1:0] i_htrans = 2'h0;
  logic [2:0] i_hsize = 3'h2;
  logic [31:0] seed = 32'hB7A0926A, exp_q[$];
  int mismatches = 0, tests_run = 0, cycles = 0;
  event rd_ev;
  wire [2:0] inds = {o_coll_ind_n, o_rx_ind_n, o_tx_ind_n};
  assign i_hready = o_hreadyout;
  nsi_top #(.P_STRETCH_CYC(P)) i_dut (.i_ref_clk, .i_nrst, .i_ext_codec_sel,
    .i_media_sel, .i_link_test_dis_n, .i_low_squelch_sel, .i_tx_active,
    .i_rx_detect, .i_coll_detect, .i_link_pulse, .i_link_pulse_rev,
    .i_rx_pkt_end, .i_rx_pkt_rev, .i_link_good, .i_dual_pin, .o_dual_pin,
    .o_dual_oe_n, .i_dual_int, .o_dual_mac, .o_int_codec_en, .o_aui_en,
    .o_tp_module_en, .o_link_pulse_gen_en, .o_link_check_en,
    .o_low_squelch_en, .o_tx_ind_n, .o_rx_ind_n, .o_coll_ind_n,
    .o_polarity_ind_n, .o_link_ind_n, .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout,
    .o_hresp);
  nsi_far_end i_far (.i_ref_clk, .i_oe_n(o_dual_oe_n),
    .i_dev_pin(o_dual_pin), .i_tx_word(ext_word), .o_pin(i_dual_pin));
  // ==========================================================
  // Clock, hang guard and shared tasks
  // ==========================================================
  initial forever #20 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      test_done();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Oldest noted read value meets each returned word
  always @(rd_ev) chk("hrdata", exp_q.pop_front(), rd_data);
  // Master holds each phase until ready is seen high
  task automatic bus(logic wr, logic [31:0] a, logic [31:0] d);
    i_hsel <= 1'b1;
    i_haddr <= a;
    i_hwrite <= wr;
    i_htrans <= 2'h2;
    do @(posedge i_ref_clk); while (i_hready !== 1'b1);
    i_htrans <= 2'h0;
    i_hsel <= 1'b0;
    i_hwdata <= d;
    do @(posedge i_ref_clk); while (i_hready !== 1'b1);
    rd_data = o_hrdata;
    chk("hresp", 32'h0, o_hresp);
    if (!wr) -> rd_ev;
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Strap order {low squelch, link test, media, codec}
  task automatic boot(logic [3:0] s);
    i_nrst <= 1'b0;
    {i_low_squelch_sel, i_link_test_dis_n, i_media_sel,
      i_ext_codec_sel} <= s; // Set only in reset
    repeat (10) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk("int_codec", !s[0], o_int_codec_en);
    chk("aui", s[1], o_aui_en);
    chk("tp", !s[1], o_tp_module_en);
    chk("pulse_gen", s[2], o_link_pulse_gen_en);
    chk("link_chk", s[2], o_link_check_en);
    chk("low_sql", s[3], o_low_squelch_en);
    chk("oe_n", s[0] ? 5'h1F : 5'h00, o_dual_oe_n);
    @(posedge i_ref_clk);
  endtask
  task automatic lamp(logic good, logic e);
    i_link_good <= good;
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk("link_lamp", e, o_link_ind_n);
    @(posedge i_ref_clk);
  endtask
  // Event, check lit, fire again mid-hold, check hold restarts
  task automatic stretch(int k);
    logic [2:0] ev;
    logic [2:0] on_n;
    ev = 3'h1 << k;
    on_n = ~ev;
    {i_coll_detect, i_rx_detect, i_tx_active} <= ev;
    @(posedge i_ref_clk);
    {i_coll_detect, i_rx_detect, i_tx_active} <= 3'h0;
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk("lamp_on", on_n, inds);
    @(posedge i_ref_clk);
    {i_coll_detect, i_rx_detect, i_tx_active} <= ev;
    @(posedge i_ref_clk);
    {i_coll_detect, i_rx_detect, i_tx_active} <= 3'h0;
    repeat (P) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk("lamp_held", on_n, inds);
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk("lamp_off", 3'h7, inds);
    @(posedge i_ref_clk);
  endtask
  task automatic pulse(logic rev);
    i_link_pulse <= 1'b1;
    i_link_pulse_rev <= rev;
    @(posedge i_ref_clk);
    i_link_pulse <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  // One packet end, reversed or not
  task automatic pkt(logic rev);
    i_rx_pkt_end <= 1'b1;
    i_rx_pkt_rev <= rev;
    @(posedge i_ref_clk);
    i_rx_pkt_end <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    boot(4'hC);
    lamp(1'b1, 1'b0);
    rd(nsi_pkg::ADDR_STATUS, 32'h21C);
    lamp(1'b0, 1'b1);
    rd(nsi_pkg::ADDR_CTRL, 32'h0);
    bus(1'b1, 32'h10, rnd());
    rd(32'h10, 32'h0);
    i_dual_int <= 5'(rnd());
    repeat (3) @(posedge i_ref_clk);
    chk("dual_pin", i_dual_int, o_dual_pin);
    chk("dual_mac", i_dual_int, o_dual_mac);
    $display("test strap_internal done");
    for (int k = 0; k < 3; k++) stretch(k);
    $display("test lamp_stretch done");
    repeat (6) pulse(1'b1);
    pulse(1'b0);
    repeat (6) pulse(1'b1);
    chk("pol_early", 1'b1, o_polarity_ind_n);
    pulse(1'b1);
    @(negedge i_ref_clk);
    chk("pol_set", 1'b0, o_polarity_ind_n);
    @(posedge i_ref_clk);
    rd(nsi_pkg::ADDR_STATUS, 32'h22C);
    bus(1'b1, nsi_pkg::ADDR_CTRL, 32'h1);
    repeat (3) @(posedge i_ref_clk);
    chk("pol_clear", 1'b1, o_polarity_ind_n);
    // A normal packet breaks the reversed run
    repeat (2) pkt(1'b1);
    pkt(1'b0);
    repeat (2) pkt(1'b1);
    chk("pol_pkt_early", 1'b1, o_polarity_ind_n);
    pkt(1'b1);
    @(negedge i_ref_clk);
    chk("pol_pkt", 1'b0, o_polarity_ind_n);
    @(posedge i_ref_clk);
    pkt(1'b0);
    @(negedge i_ref_clk);
    chk("pol_pkt_clr", 1'b1, o_polarity_ind_n);
    @(posedge i_ref_clk);
    $display("test polarity done");
    bus(1'b1, nsi_pkg::ADDR_CTRL, 32'h2);
    repeat (2) @(posedge i_ref_clk);
    chk("lamp_test", 5'h00, {o_link_ind_n, o_polarity_ind_n, inds});
    rd(nsi_pkg::ADDR_CTRL, 32'h2);
    bus(1'b1, nsi_pkg::ADDR_CTRL, 32'h0);
    $display("test lamp_test done");
    boot(4'h3);
    lamp(1'b1, 1'b1);
    ext_word <= 5'(rnd());
    repeat (8) @(posedge i_ref_clk);
    chk("ext_mac", ext_word, o_dual_mac);
    $display("test strap_external done");
    boot(4'h0);
    lamp(1'b0, 1'b0);
    $display("test link_test_off done");
    test_done();
  end
endmodule
